// ==== rtl/pcf_align_regs.sv ====
// frame alignment register bank with pcm and cfi edge logic
`timescale 1ns/100ps
`default_nettype none
module pcf_align_regs
  import pcf_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // register port
  input wire logic [PCF_ADDR_W-1:0] reg_addr_i,
  input wire logic [PCF_DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [PCF_DATA_W-1:0] reg_rdata_o,
  // pcm highway
  input wire logic pcm_clk_i,
  input wire logic pcm_sync_i,
  input wire logic pcm_rxd_i,
  input wire logic pcm_tx_bit_i,
  input wire logic [PCF_CNT_W-1:0] pcm_frame_last_i,
  output logic pcm_txd_o,
  output logic ds_rx_bit_o,
  output logic ds_rx_valid_o,
  output logic [PCF_CNT_W-1:0] ds_count_o,
  output logic [PCF_CNT_W-1:0] us_count_o,
  // configurable frame interface
  input wire logic cfi_data_clock_i,
  input wire logic cfi_rxd_i,
  input wire logic cfi_tx_bit_i,
  output logic cfi_txd_o,
  output logic cfi_rx_bit_o,
  // configuration seen by the rest of the device
  output logic [PCF_DATA_W-1:0] cfi_mode_first_o,
  output logic [PCF_DATA_W-1:0] cfi_mode_second_o,
  output logic [PCF_DATA_W-1:0] cfi_bit_number_o
);

  ////////////////////////////////////////////////////////////////////////////
  // register file

  logic [7:0] pcm_downstream_offset;
  logic [7:0] pcm_upstream_offset;
  logic [7:0] pcm_clock_shift;
  logic [7:0] next_ds_ofs;
  logic [7:0] next_us_ofs;
  logic [7:0] next_clk_shift;
  logic [7:0] next_mode1;
  logic [7:0] next_mode2;
  logic [7:0] next_bitnum;
  logic [7:0] next_rdata;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] reg_adr);
    return a == reg_adr;
  endfunction

  always_comb begin
    next_ds_ofs = pcm_downstream_offset;
    next_us_ofs = pcm_upstream_offset;
    next_clk_shift = pcm_clock_shift;
    next_mode1 = cfi_mode_first_o;
    next_mode2 = cfi_mode_second_o;
    next_bitnum = cfi_bit_number_o;
    next_rdata = PCF_RD_NONE;
    if (reg_wr_i) begin
      if (hit(reg_addr_i, PCF_ADR_DS_OFS)) begin
        next_ds_ofs = reg_wdata_i;
      end
      if (hit(reg_addr_i, PCF_ADR_US_OFS)) begin
        next_us_ofs = reg_wdata_i;
      end
      // the top bit is unused and kept at zero whatever is written
      if (hit(reg_addr_i, PCF_ADR_CLK_SHIFT)) begin
        next_clk_shift = reg_wdata_i & PCF_CLK_SHIFT_MASK;
      end
      if (hit(reg_addr_i, PCF_ADR_CFI_MODE1)) begin
        next_mode1 = reg_wdata_i;
      end
      if (hit(reg_addr_i, PCF_ADR_CFI_MODE2)) begin
        next_mode2 = reg_wdata_i;
      end
      if (hit(reg_addr_i, PCF_ADR_CFI_BITNUM)) begin
        next_bitnum = reg_wdata_i;
      end
    end
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        PCF_ADR_DS_OFS: next_rdata = pcm_downstream_offset;
        PCF_ADR_US_OFS: next_rdata = pcm_upstream_offset;
        PCF_ADR_CLK_SHIFT: next_rdata = pcm_clock_shift;
        PCF_ADR_CFI_MODE1: next_rdata = cfi_mode_first_o;
        PCF_ADR_CFI_MODE2: next_rdata = cfi_mode_second_o;
        PCF_ADR_CFI_BITNUM: next_rdata = cfi_bit_number_o;
        default: next_rdata = PCF_RD_NONE;
      endcase
    end
  end

  // read data stands only in the cycle after the strobe, zero otherwise
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pcm_downstream_offset <= PCF_RST_DS_OFS;
      pcm_upstream_offset <= PCF_RST_US_OFS;
      pcm_clock_shift <= PCF_RST_CLK_SHIFT;
      cfi_mode_first_o <= PCF_RST_CFI_MODE1;
      cfi_mode_second_o <= PCF_RST_CFI_MODE2;
      cfi_bit_number_o <= PCF_RST_CFI_BITNUM;
      reg_rdata_o <= PCF_RD_NONE;
    end else begin
      pcm_downstream_offset <= next_ds_ofs;
      pcm_upstream_offset <= next_us_ofs;
      pcm_clock_shift <= next_clk_shift;
      cfi_mode_first_o <= next_mode1;
      cfi_mode_second_o <= next_mode2;
      cfi_bit_number_o <= next_bitnum;
      reg_rdata_o <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // edge detection on the sampled link clocks

  logic pcm_clk_q;
  logic cfi_clk_q;
  logic pcm_sync_q;
  logic pcm_rise;
  logic pcm_fall;
  logic cfi_rise;
  logic cfi_fall;
  logic frame_sync;
  logic ds_edge_sel;
  logic us_edge_sel;
  logic cfi_tx_edge;
  logic cfi_rx_edge;
  logic ds_take;
  logic us_launch;
  logic cfi_launch;
  logic cfi_take;

  // edges are seen one system cycle late; the pcm clock must stay well below
  // half the system clock for this to hold
  assign pcm_rise = pcm_clk_i && !pcm_clk_q;
  assign pcm_fall = !pcm_clk_i && pcm_clk_q;
  assign cfi_rise = cfi_data_clock_i && !cfi_clk_q;
  assign cfi_fall = !cfi_data_clock_i && cfi_clk_q;
  assign frame_sync = pcm_sync_i && !pcm_sync_q;

  assign ds_edge_sel = pcm_clock_shift[PCF_CS_DS_EDGE];
  assign us_edge_sel = pcm_clock_shift[PCF_CS_US_EDGE];
  assign cfi_tx_edge = cfi_mode_second_o[PCF_CM2_TX_EDGE];
  assign cfi_rx_edge = cfi_mode_second_o[PCF_CM2_RX_EDGE];

  assign ds_take = ds_edge_sel ? pcm_rise : pcm_fall;
  assign us_launch = us_edge_sel ? pcm_rise : pcm_fall;
  assign cfi_launch = cfi_tx_edge ? cfi_fall : cfi_rise;
  assign cfi_take = cfi_rx_edge ? cfi_rise : cfi_fall;

  ////////////////////////////////////////////////////////////////////////////
  // data path

  logic next_pcm_txd;
  logic next_ds_bit;
  logic next_cfi_txd;
  logic next_cfi_rx;

  always_comb begin
    next_pcm_txd = us_launch ? pcm_tx_bit_i : pcm_txd_o;
    next_ds_bit = ds_take ? pcm_rxd_i : ds_rx_bit_o;
    next_cfi_txd = cfi_launch ? cfi_tx_bit_i : cfi_txd_o;
    next_cfi_rx = cfi_take ? cfi_rxd_i : cfi_rx_bit_o;
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pcm_clk_q <= 1'b0;
      cfi_clk_q <= 1'b0;
      pcm_sync_q <= 1'b0;
      pcm_txd_o <= 1'b0;
      ds_rx_bit_o <= 1'b0;
      ds_rx_valid_o <= 1'b0;
      cfi_txd_o <= 1'b0;
      cfi_rx_bit_o <= 1'b0;
    end else begin
      pcm_clk_q <= pcm_clk_i;
      cfi_clk_q <= cfi_data_clock_i;
      pcm_sync_q <= pcm_sync_i;
      pcm_txd_o <= next_pcm_txd;
      ds_rx_bit_o <= next_ds_bit;
      ds_rx_valid_o <= ds_take;
      cfi_txd_o <= next_cfi_txd;
      cfi_rx_bit_o <= next_cfi_rx;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // frame bit counters

  logic [PCF_CNT_W-1:0] ds_offset;
  logic [PCF_CNT_W-1:0] us_offset;

  assign ds_offset = {pcm_downstream_offset, pcm_clock_shift[PCF_CS_DS_LO +: PCF_LOW_OFS_W]};
  assign us_offset = {pcm_upstream_offset, pcm_clock_shift[PCF_CS_US_LO +: PCF_LOW_OFS_W]};

  pcf_frame_counter u_ds_counter (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .step_i(ds_take),
    .sync_i(frame_sync),
    .offset_i(ds_offset),
    .last_i(pcm_frame_last_i),
    .count_o(ds_count_o)
  );

  pcf_frame_counter u_us_counter (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .step_i(us_launch),
    .sync_i(frame_sync),
    .offset_i(us_offset),
    .last_i(pcm_frame_last_i),
    .count_o(us_count_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  a_ds_rise_sample: assert property ((pcm_rise && ds_edge_sel) |=>
    (ds_rx_valid_o && ds_rx_bit_o == $past(pcm_rxd_i)))
    else $error("downstream bit not taken on rising edge");

  a_ds_edge_only: assert property (ds_rx_valid_o |->
    $past(ds_edge_sel ? (pcm_clk_i && !pcm_clk_q) : (!pcm_clk_i && pcm_clk_q)))
    else $error("downstream bit taken on the wrong edge");

  a_us_fall_launch: assert property ((pcm_fall && !us_edge_sel) |=>
    pcm_txd_o == $past(pcm_tx_bit_i))
    else $error("upstream bit not launched on falling edge");

  a_us_tx_hold: assert property ((!pcm_rise && !pcm_fall) |=> $stable(pcm_txd_o))
    else $error("upstream bit changed without a clock edge");

  a_cfi_tx_edge: assert property ((cfi_fall && cfi_tx_edge) or (cfi_rise && !cfi_tx_edge) |=>
    cfi_txd_o == $past(cfi_tx_bit_i))
    else $error("cfi transmit bit not launched on selected edge");

  a_us_ofs_rdback: assert property ((reg_wr_i && reg_addr_i == PCF_ADR_US_OFS) ##1
    (reg_rd_i && reg_addr_i == PCF_ADR_US_OFS) |=> reg_rdata_o == $past(reg_wdata_i, 2))
    else $error("upstream offset readback mismatch");

  a_clk_shift_rdback: assert property ((reg_wr_i && reg_addr_i == PCF_ADR_CLK_SHIFT) ##1
    (reg_rd_i && reg_addr_i == PCF_ADR_CLK_SHIFT) |=>
    reg_rdata_o == ($past(reg_wdata_i, 2) & PCF_CLK_SHIFT_MASK))
    else $error("clock shift readback mismatch");

  a_mode2_rdback: assert property ((reg_wr_i && reg_addr_i == PCF_ADR_CFI_MODE2) ##1
    (reg_rd_i && reg_addr_i == PCF_ADR_CFI_MODE2) |=> reg_rdata_o == $past(reg_wdata_i, 2))
    else $error("cfi mode two readback mismatch");

  a_ds_resync: assert property (frame_sync |=> ds_count_o == $past(ds_offset))
    else $error("downstream counter not reloaded at frame sync");

  a_us_resync: assert property (frame_sync |=> us_count_o == $past(us_offset))
    else $error("upstream counter not reloaded at frame sync");

  a_rdata_idle: assert property (!reg_rd_i |=> reg_rdata_o == PCF_RD_NONE)
    else $error("read data present without a read");

  c_ds_resync: cover property (frame_sync && ds_offset != PCF_CNT_ZERO);
  c_us_rise_launch: cover property (pcm_rise && us_edge_sel);
  c_cfi_fall_launch: cover property (cfi_fall && cfi_tx_edge);
  c_mode2_read: cover property (reg_rd_i && reg_addr_i == PCF_ADR_CFI_MODE2);

endmodule
`default_nettype wire

// ==== shared/pcf_pkg.sv ====
// constants of the pcm and cfi frame alignment register bank
package pcf_pkg;

  localparam int PCF_ADDR_W = 8;
  localparam int PCF_DATA_W = 8;
  localparam int PCF_CNT_W = 10;

  // register addresses, bank select bit already folded in
  localparam logic [7:0] PCF_ADR_DS_OFS = 8'h24;
  localparam logic [7:0] PCF_ADR_US_OFS = 8'h26;
  localparam logic [7:0] PCF_ADR_CLK_SHIFT = 8'h28;
  localparam logic [7:0] PCF_ADR_CFI_MODE1 = 8'h2c;
  localparam logic [7:0] PCF_ADR_CFI_MODE2 = 8'h2e;
  localparam logic [7:0] PCF_ADR_CFI_BITNUM = 8'h30;

  // reset values
  localparam logic [7:0] PCF_RST_DS_OFS = 8'h00;
  localparam logic [7:0] PCF_RST_US_OFS = 8'h00;
  localparam logic [7:0] PCF_RST_CLK_SHIFT = 8'h00;
  localparam logic [7:0] PCF_RST_CFI_MODE1 = 8'h00;
  localparam logic [7:0] PCF_RST_CFI_MODE2 = 8'h00;
  localparam logic [7:0] PCF_RST_CFI_BITNUM = 8'hff;
  localparam logic [7:0] PCF_RD_NONE = 8'h00;

  // clock shift register fields
  localparam logic [7:0] PCF_CLK_SHIFT_MASK = 8'h7f;
  localparam int PCF_CS_DS_LO = 5;
  localparam int PCF_CS_DS_EDGE = 4;
  localparam int PCF_CS_US_LO = 1;
  localparam int PCF_CS_US_EDGE = 0;
  localparam int PCF_LOW_OFS_W = 2;

  // cfi mode register two fields
  localparam int PCF_CM2_TX_EDGE = 3;
  localparam int PCF_CM2_RX_EDGE = 2;

  localparam logic [PCF_CNT_W-1:0] PCF_CNT_ZERO = 10'h000;
  localparam logic [PCF_CNT_W-1:0] PCF_CNT_ONE = 10'h001;

endpackage

// ==== rtl/pcf_frame_counter.sv ====
// bit position counter of one pcm direction, reloaded on frame sync
`timescale 1ns/100ps
`default_nettype none
module pcf_frame_counter
  import pcf_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // control
  input wire logic step_i,
  input wire logic sync_i,
  input wire logic [PCF_CNT_W-1:0] offset_i,
  input wire logic [PCF_CNT_W-1:0] last_i,
  // state
  output logic [PCF_CNT_W-1:0] count_o
);

  logic [PCF_CNT_W-1:0] next_count;

  // sync wins over a step in the same cycle so the frame start is never missed
  always_comb begin
    next_count = count_o;
    if (sync_i) begin
      next_count = offset_i;
    end else if (step_i) begin
      if (count_o == last_i) begin
        next_count = PCF_CNT_ZERO;
      end else begin
        next_count = count_o + PCF_CNT_ONE;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_o <= PCF_CNT_ZERO;
    end else begin
      count_o <= next_count;
    end
  end

endmodule
`default_nettype wire

// ==== test/pcf_align_regs_test.sv ====
// self-checking testbench of the frame alignment register bank
`timescale 1ns/100ps
`default_nettype none
module pcf_align_regs_test;
  import pcf_pkg::*;
  logic sys_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [7:0] reg_rdata_o;
  logic pcm_clk_i = 1'b0;
  logic pcm_sync_i = 1'b0;
  logic pcm_rxd_i = 1'b0;
  logic pcm_tx_bit_i = 1'b0;
  logic [9:0] pcm_frame_last_i = 10'h00a;
  logic pcm_txd_o, ds_rx_bit_o, ds_rx_valid_o;
  logic [9:0] ds_count_o, us_count_o;
  logic cfi_data_clock_i = 1'b0;
  logic cfi_rxd_i = 1'b0;
  logic cfi_tx_bit_i = 1'b0;
  logic cfi_txd_o, cfi_rx_bit_o;
  logic [7:0] cfi_mode_first_o, cfi_mode_second_o, cfi_bit_number_o;
  int err_count = 0;
  int total_checks = 0;

  pcf_align_regs dut_u (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .pcm_clk_i(pcm_clk_i),
    .pcm_sync_i(pcm_sync_i), .pcm_rxd_i(pcm_rxd_i), .pcm_tx_bit_i(pcm_tx_bit_i),
    .pcm_frame_last_i(pcm_frame_last_i), .pcm_txd_o(pcm_txd_o), .ds_rx_bit_o(ds_rx_bit_o),
    .ds_rx_valid_o(ds_rx_valid_o), .ds_count_o(ds_count_o), .us_count_o(us_count_o),
    .cfi_data_clock_i(cfi_data_clock_i), .cfi_rxd_i(cfi_rxd_i), .cfi_tx_bit_i(cfi_tx_bit_i),
    .cfi_txd_o(cfi_txd_o), .cfi_rx_bit_o(cfi_rx_bit_o), .cfi_mode_first_o(cfi_mode_first_o),
    .cfi_mode_second_o(cfi_mode_second_o), .cfi_bit_number_o(cfi_bit_number_o)
  );

  always #20 sys_clk_i = ~sys_clk_i;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [9:0] exp, input logic [9:0] got);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    #1;
    chk("reg_rdata_o", {2'h0, exp}, {2'h0, reg_rdata_o});
  endtask

  // write then read the same register with no gap, so the readback checks see it
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, input logic [7:0] exp);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
    reg_rd_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    #1;
    chk("reg_rdata_o", {2'h0, exp}, {2'h0, reg_rdata_o});
  endtask

  // each clock level is held two system cycles, results land one cycle after the change
  task automatic pcm_step(input logic lvl, input logic d);
    @(posedge sys_clk_i);
    pcm_clk_i <= lvl;
    pcm_rxd_i <= d;
    pcm_tx_bit_i <= d;
    @(posedge sys_clk_i);
    #1;
  endtask

  task automatic cfi_step(input logic lvl, input logic rx, input logic tx, input logic erx, input logic etx);
    @(posedge sys_clk_i);
    cfi_data_clock_i <= lvl;
    cfi_rxd_i <= rx;
    cfi_tx_bit_i <= tx;
    @(posedge sys_clk_i);
    #1;
    chk("cfi_rx_bit_o", {9'h0, erx}, {9'h0, cfi_rx_bit_o});
    chk("cfi_txd_o", {9'h0, etx}, {9'h0, cfi_txd_o});
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_reset_values();
    chk("cfi_bit_number_o", 10'h0ff, {2'h0, cfi_bit_number_o});
    rd(8'h24, 8'h00);
    rd(8'h26, 8'h00);
    rd(8'h28, 8'h00);
    rd(8'h2c, 8'h00);
    rd(8'h2e, 8'h00);
    rd(8'h30, 8'hff);
    rd(8'h20, 8'h00);
  endtask

  task automatic test_reg_access();
    wr(8'h26, 8'ha5);
    rd(8'h26, 8'ha5);
    wr(8'h28, 8'hd3);
    rd(8'h28, 8'h53);
    wr(8'h2e, 8'h0c);
    rd(8'h2e, 8'h0c);
    chk("cfi_mode_second_o", 10'h00c, {2'h0, cfi_mode_second_o});
    wr_rd(8'h26, 8'h5a, 8'h5a);
    wr_rd(8'h28, 8'h66, 8'h66);
    wr_rd(8'h2e, 8'h08, 8'h08);
    wr(8'h2c, 8'h41);
    #1;
    chk("cfi_mode_first_o", 10'h041, {2'h0, cfi_mode_first_o});
    wr(8'h30, 8'h3c);
    #1;
    chk("cfi_bit_number_o", 10'h03c, {2'h0, cfi_bit_number_o});
    wr(8'h3e, 8'h77);
    rd(8'h3e, 8'h00);
    rd(8'h24, 8'h00);
  endtask

  // offsets: downstream {01,10}=6, upstream {02,01}=9, frame last bit 10
  task automatic test_counters_and_edges();
    wr(8'h24, 8'h01);
    wr(8'h26, 8'h02);
    wr(8'h28, 8'h53);
    @(posedge sys_clk_i);
    pcm_sync_i <= 1'b1;
    @(posedge sys_clk_i);
    #1;
    chk("ds_count_o", 10'h006, ds_count_o);
    chk("us_count_o", 10'h009, us_count_o);
    @(posedge sys_clk_i);
    pcm_sync_i <= 1'b0;
    pcm_step(1'b1, 1'b1);
    chk("ds_rx_valid_o", 10'h001, {9'h0, ds_rx_valid_o});
    chk("ds_rx_bit_o", 10'h001, {9'h0, ds_rx_bit_o});
    chk("pcm_txd_o", 10'h001, {9'h0, pcm_txd_o});
    chk("ds_count_o", 10'h007, ds_count_o);
    chk("us_count_o", 10'h00a, us_count_o);
    pcm_step(1'b0, 1'b0);
    chk("ds_rx_bit_o", 10'h001, {9'h0, ds_rx_bit_o});
    chk("pcm_txd_o", 10'h001, {9'h0, pcm_txd_o});
    chk("ds_count_o", 10'h007, ds_count_o);
    pcm_step(1'b1, 1'b0);
    chk("ds_count_o", 10'h008, ds_count_o);
    chk("us_count_o", 10'h000, us_count_o);
    wr(8'h28, 8'h00);
    pcm_step(1'b0, 1'b1);
    chk("ds_rx_bit_o", 10'h001, {9'h0, ds_rx_bit_o});
    chk("pcm_txd_o", 10'h001, {9'h0, pcm_txd_o});
    pcm_step(1'b1, 1'b0);
    chk("ds_rx_bit_o", 10'h001, {9'h0, ds_rx_bit_o});
    chk("pcm_txd_o", 10'h001, {9'h0, pcm_txd_o});
  endtask

  // transmit-edge set: launch on fall; receive-edge set: sample on rise
  task automatic test_cfi_edges();
    wr(8'h2e, 8'h0c);
    cfi_step(1'b1, 1'b1, 1'b1, 1'b1, 1'b0);
    cfi_step(1'b0, 1'b0, 1'b1, 1'b1, 1'b1);
    wr(8'h2e, 8'h00);
    cfi_step(1'b1, 1'b1, 1'b0, 1'b1, 1'b0);
    cfi_step(1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    @(posedge sys_clk_i);
    #1;
    test_reset_values();
    test_reg_access();
    test_counters_and_edges();
    test_cfi_edges();
    results();
  end

  // the whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge sys_clk_i);
    err_count++;
    $display("[ERR] watchdog expected done seen hang");
    results();
  end
endmodule
`default_nettype wire
